//--- event_source.sv
// Purpose: far-side source of level changes on a count pin
// Assumes: a request is given while idle
// Notes:   pin rests at its last level between requests
`timescale 1ns/1ps
module event_source (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // request: number of level changes
  input  wire logic [3:0] edges,
  // pin side
  output logic            pin,
  output logic            busy
);
  logic [3:0] left_q;
  logic [1:0] div_q;
  assign busy = left_q != 4'h0;
  // one change every 4 clocks keeps the pin at a quarter of clk or slower
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 4'h0;
      div_q  <= 2'h0;
      pin    <= 1'b0;
    end else if (!busy) begin
      left_q <= edges;
      div_q  <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        pin    <= ~pin;
        left_q <= left_q - 4'h1;
      end
    end
  end
endmodule

//--- mc_chan_if.sv
// Purpose: control and status of one counter channel
// Assumes: single clock domain
// Notes:   ctrl side is the register block, unit side the counter
`timescale 1ns/1ps
interface mc_chan_if;
  logic        tick;
  logic        load_evt;
  logic        cnt_wr;
  logic        latch_wr;
  logic        flag_clr;
  logic [15:0] wdata;
  logic [15:0] count;
  logic [15:0] latch;
  logic        flag;
  modport unit (input tick, load_evt, cnt_wr, latch_wr, flag_clr, wdata,
                output count, latch, flag);
  modport ctrl (output tick, load_evt, cnt_wr, latch_wr, flag_clr, wdata,
                input count, latch, flag);
endinterface

//--- modulus_counter_unit.sv
// Purpose: 16-bit counter with modulus latch and overflow flag
// Assumes: tick is a one-cycle enable
// Notes:   a counter write beats a tick in the same cycle
`timescale 1ns/1ps
module modulus_counter_unit (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // channel
  mc_chan_if.unit   ch
);
  logic [15:0] count_q;
  logic [15:0] latch_q;
  logic        flag_q;
  logic        ovf;

  assign ovf = ch.tick && !ch.cnt_wr && (count_q == modulus_timer_pkg::CNT_MAX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= modulus_timer_pkg::CNT_RST;
    end else if (ch.cnt_wr) begin
      count_q <= ch.wdata;
    end else if (ovf || ch.load_evt) begin
      count_q <= latch_q;
    end else if (ch.tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= modulus_timer_pkg::LATCH_RST;
    end else if (ch.cnt_wr || ch.latch_wr) begin
      latch_q <= ch.wdata;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (ovf) begin
      flag_q <= 1'b1;
    end else if (ch.flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  assign ch.count = count_q;
  assign ch.latch = latch_q;
  assign ch.flag  = flag_q;
endmodule

//--- modulus_timer.sv
// Purpose: three modulus counter channels with prescaler, time base
//          drive and interrupt arbitration
// Assumes: register port as plain strobes, read data one cycle later
// Notes:   channel registers are decoded by word address
//
// What this block does
// - 16-bit readable counter with incrementer
// - counter write loads counter and latch
// - overflow reloads counter from latch
// - every overflow sets overflow flag
// - latch all ones overflows every pulse
// - latch zero gives full-range free run
// - 3-bit select picks eight count sources
// - select change ignores spurious pin edges
// - read-only bit shows synchronised pin level
// - two bits choose driven time base
// - request when flag set, level nonzero
// - contend only when level exceeds mask
// - arbitration number from config and channel
// - vector is upper bits plus submodule number
// - unused bits and addresses read zero
// - three independent channels, own registers
// - no counting until prescaler run set
// - latch write updates only the latch
// - load pin edge loads latch into counter
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module modulus_timer #(
  parameter int CHANNELS = modulus_timer_pkg::CHANNELS,
  parameter int PRESC_W  = modulus_timer_pkg::PRESC_W
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [5:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // pins
  input  wire logic [2:0]  external_count_input,
  input  wire logic [2:0]  load_input,
  // time base buses
  output logic      [15:0] tb_first,
  output logic             tb_first_drv,
  output logic      [15:0] tb_second,
  output logic             tb_second_drv,
  // interrupt arbitration
  input  wire logic [2:0]  ip_mask,
  input  wire logic        iack,
  output logic      [2:0]  irq_level,
  output logic      [3:0]  arb_number,
  output logic      [7:0]  vector,
  output logic             vector_valid
);
  // index of the addressed channel, CHANNELS when none
  function automatic logic [1:0] chan_of(input logic [5:0] a);
    logic [1:0] r;
    r = 2'(CHANNELS);
    for (int i = 0; i < CHANNELS; i++) begin
      if (a[5:2] == modulus_timer_pkg::CH_BASE_W + 4'(i)) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  logic [15:0] cfg_q;
  logic [15:0] sc_q [CHANNELS];
  logic [2:0]  sel_hold_q;
  logic [15:0] rdata_q;
  logic [PRESC_W-1:0] presc_q;
  logic [5:0]  tap;
  logic        run;
  logic [1:0]  wch;
  logic [1:0]  rch;
  logic [2:0]  cnt_level;
  logic [2:0]  cnt_rise;
  logic [2:0]  cnt_fall;
  logic [2:0]  ld_rise;
  logic [2:0]  ld_fall;
  logic [2:0]  tick;
  logic [15:0] count_v [CHANNELS];
  logic [15:0] latch_v [CHANNELS];
  logic [2:0]  flag_v;
  logic [15:0] tb1_q;
  logic        tb1_en_q;
  logic [15:0] tb2_q;
  logic        tb2_en_q;
  logic [2:0]  lvl_q;
  logic [3:0]  arb_q;
  logic [1:0]  win_q;
  logic [7:0]  vec_q;
  logic        vec_v_q;
  logic [2:0]  best_lvl;
  logic [1:0]  best_ch;
  logic        any_req;

  assign run = cfg_q[modulus_timer_pkg::CFG_RUN];
  assign wch = chan_of(addr);
  assign rch = chan_of(addr);

  // configuration register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= modulus_timer_pkg::CFG_RST;
    end else if (wr && addr == modulus_timer_pkg::CFG_OFS) begin
      cfg_q <= wdata & 16'h01C7;
    end
  end

  // prescaler: taps are one-cycle enables at clk/2 .. clk/64
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
    end else if (run) begin
      presc_q <= presc_q + PRESC_W'(1);
    end else begin
      presc_q <= '0;
    end
  end

  // one enable per tap, the part-select bounds are fixed per tap
  for (genvar k = 0; k < 6; k++) begin : g_tap
    assign tap[k] = run && (&presc_q[k:0]);
  end

  // per-channel status/control, counter, pins
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    mc_chan_if chif ();
    logic       sc_hit;
    logic       sel_new;
    logic [2:0] sel;
    logic [1:0] lde;

    assign sc_hit = wr && wch == 2'(c) && addr[1:0] == modulus_timer_pkg::SC_OFS;
    assign sel_new = sc_hit
      && wdata[modulus_timer_pkg::SC_CLK_LO +: 3]
         != sc_q[c][modulus_timer_pkg::SC_CLK_LO +: 3];
    assign sel = sc_q[c][modulus_timer_pkg::SC_CLK_LO +: 3];
    assign lde = sc_q[c][modulus_timer_pkg::SC_LDE_LO +: 2];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sc_q[c] <= modulus_timer_pkg::SC_RST;
      end else if (sc_hit) begin
        sc_q[c] <= wdata & 16'h3F37;
      end
    end

    // pin edges are blanked while the source select settles
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sel_hold_q[c] <= 1'b0;
      end else begin
        sel_hold_q[c] <= sel_new;
      end
    end

    pin_edge u_cnt_pin (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (external_count_input[c]),
      .hold  (sel_new || sel_hold_q[c]),
      .level (cnt_level[c]),
      .rise  (cnt_rise[c]),
      .fall  (cnt_fall[c])
    );

    pin_edge u_ld_pin (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (load_input[c]),
      .hold  (1'b0),
      .level (),
      .rise  (ld_rise[c]),
      .fall  (ld_fall[c])
    );

    always_comb begin
      case (sel)
        modulus_timer_pkg::SRC_RISE: tick[c] = run && cnt_rise[c] && !sel_new;
        modulus_timer_pkg::SRC_FALL: tick[c] = run && cnt_fall[c] && !sel_new;
        default:                     tick[c] = tap[sel] && !sel_new;
      endcase
    end

    assign chif.tick     = tick[c];
    assign chif.load_evt = (ld_rise[c] && lde[0]) || (ld_fall[c] && lde[1]);
    assign chif.cnt_wr   = wr && wch == 2'(c) && addr[1:0] == modulus_timer_pkg::CNT_OFS;
    assign chif.latch_wr = wr && wch == 2'(c) && addr[1:0] == modulus_timer_pkg::LATCH_OFS;
    assign chif.flag_clr = sc_hit && !wdata[modulus_timer_pkg::SC_FLAG];
    assign chif.wdata    = wdata;
    assign count_v[c]    = chif.count;
    assign latch_v[c]    = chif.latch;
    assign flag_v[c]     = chif.flag;

    modulus_counter_unit u_unit (
      .clk   (clk),
      .rst_n (rst_n),
      .ch    (chif)
    );
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      rdata_q <= 16'h0000;
      if (addr == modulus_timer_pkg::CFG_OFS) begin
        rdata_q <= cfg_q;
      end else if (rch != 2'(CHANNELS)) begin
        case (addr[1:0])
          modulus_timer_pkg::SC_OFS: begin
            rdata_q <= sc_q[rch];
            rdata_q[modulus_timer_pkg::SC_LEVEL] <= cnt_level[rch];
            rdata_q[modulus_timer_pkg::SC_FLAG]  <= flag_v[rch];
          end
          modulus_timer_pkg::CNT_OFS:   rdata_q <= count_v[rch];
          modulus_timer_pkg::LATCH_OFS: rdata_q <= latch_v[rch];
          default:                      rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // time base buses: lowest channel selecting a bus drives it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tb1_q    <= 16'h0000;
      tb1_en_q <= 1'b0;
      tb2_q    <= 16'h0000;
      tb2_en_q <= 1'b0;
    end else begin
      tb1_q    <= 16'h0000;
      tb1_en_q <= 1'b0;
      tb2_q    <= 16'h0000;
      tb2_en_q <= 1'b0;
      for (int i = CHANNELS - 1; i >= 0; i--) begin
        if (sc_q[i][modulus_timer_pkg::SC_DRV1]) begin
          tb1_q    <= count_v[i];
          tb1_en_q <= 1'b1;
        end
        if (sc_q[i][modulus_timer_pkg::SC_DRV2]) begin
          tb2_q    <= count_v[i];
          tb2_en_q <= 1'b1;
        end
      end
    end
  end

  // pick the highest level above the mask, lower channel on a tie
  always_comb begin
    best_lvl = 3'h0;
    best_ch  = 2'h0;
    any_req  = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (flag_v[i]
          && sc_q[i][modulus_timer_pkg::SC_IL_LO +: 3] != 3'h0
          && sc_q[i][modulus_timer_pkg::SC_IL_LO +: 3] > ip_mask
          && sc_q[i][modulus_timer_pkg::SC_IL_LO +: 3] > best_lvl) begin
        best_lvl = sc_q[i][modulus_timer_pkg::SC_IL_LO +: 3];
        best_ch  = 2'(i);
        any_req  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 3'h0;
      arb_q <= 4'h0;
      win_q <= 2'h0;
    end else begin
      lvl_q <= best_lvl;
      win_q <= best_ch;
      arb_q <= any_req
        ? {sc_q[best_ch][modulus_timer_pkg::SC_ARB3],
           cfg_q[modulus_timer_pkg::CFG_ARB_LO +: 3]}
        : 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_q   <= 8'h00;
      vec_v_q <= 1'b0;
    end else begin
      vec_v_q <= iack && lvl_q != 3'h0;
      if (iack && lvl_q != 3'h0) begin
        vec_q <= {cfg_q[modulus_timer_pkg::CFG_VEC_LO +: 2],
                  modulus_timer_pkg::SUBMOD_BASE + 6'(win_q)};
      end
    end
  end

  assign rdata         = rdata_q;
  assign tb_first      = tb1_q;
  assign tb_first_drv  = tb1_en_q;
  assign tb_second     = tb2_q;
  assign tb_second_drv = tb2_en_q;
  assign irq_level     = lvl_q;
  assign arb_number    = arb_q;
  assign vector        = vec_q;
  assign vector_valid  = vec_v_q;
endmodule

//--- modulus_timer_asserts.sv
// Purpose: port checks of the modulus timer
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every modulus_timer instance
`timescale 1ns/1ps
module modulus_timer_asserts #(
  parameter int CHANNELS = 3
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register port
  input wire logic [5:0]  addr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // time base buses
  input wire logic [15:0] tb_first,
  input wire logic        tb_first_drv,
  input wire logic [15:0] tb_second,
  input wire logic        tb_second_drv,
  // interrupt arbitration
  input wire logic [2:0]  ip_mask,
  input wire logic        iack,
  input wire logic [2:0]  irq_level,
  input wire logic [3:0]  arb_number,
  input wire logic [7:0]  vector,
  input wire logic        vector_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  vector_answer_a: assert property (
    iack && irq_level != 3'h0 |=> vector_valid) else $error("no vector after acknowledge");
  vector_cause_a: assert property (
    vector_valid |-> $past(iack) && $past(irq_level) != 3'h0) else $error("stray vector");
  vector_number_a: assert property (
    vector_valid |-> vector[5:0] >= modulus_timer_pkg::SUBMOD_BASE
      && vector[5:0] < modulus_timer_pkg::SUBMOD_BASE + CHANNELS)
    else $error("vector low bits not a channel number");
  level_mask_a: assert property (
    irq_level != 3'h0 && $stable(ip_mask) |-> irq_level > ip_mask)
    else $error("request not above mask");
  arb_idle_a: assert property (
    irq_level == 3'h0 |-> arb_number == 4'h0) else $error("arbitration number without request");
  first_idle_a: assert property (
    !tb_first_drv |-> tb_first == 16'h0000) else $error("first bus driven while off");
  second_idle_a: assert property (
    !tb_second_drv |-> tb_second == 16'h0000) else $error("second bus driven while off");
  hole_read_a: assert property (
    rd && addr == 6'h3F |=> rdata == 16'h0000) else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !rd |=> $stable(rdata)) else $error("read data moved without read");
  cover property (iack && irq_level != 3'h0);
  cover property (tb_first_drv);
  cover property (tb_second_drv);
endmodule
bind modulus_timer modulus_timer_asserts #(.CHANNELS(CHANNELS)) checks (
  .clk, .rst_n, .addr, .rd, .rdata, .tb_first, .tb_first_drv, .tb_second,
  .tb_second_drv, .ip_mask, .iack, .irq_level, .arb_number, .vector, .vector_valid
);

//--- modulus_timer_pkg.sv
// Purpose: shared constants of the modulus timer
// Assumes: 16-bit register port, word addressed
// Notes:   channel registers sit at 4*(CH_BASE_W + channel) + offset
package modulus_timer_pkg;
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 16;
  localparam int CHANNELS = 3;
  localparam int PRESC_W  = 6;
  // register map
  localparam logic [5:0] CFG_OFS   = 6'h00;
  localparam logic [3:0] CH_BASE_W = 4'h4;
  localparam logic [1:0] SC_OFS    = 2'h0;
  localparam logic [1:0] CNT_OFS   = 2'h1;
  localparam logic [1:0] LATCH_OFS = 2'h2;
  // configuration register fields
  localparam int CFG_ARB_LO = 0;
  localparam int CFG_VEC_LO = 6;
  localparam int CFG_RUN    = 8;
  // status/control register fields
  localparam int SC_CLK_LO  = 0;
  localparam int SC_LDE_LO  = 4;
  localparam int SC_IL_LO   = 8;
  localparam int SC_ARB3    = 11;
  localparam int SC_DRV1    = 12;
  localparam int SC_DRV2    = 13;
  localparam int SC_LEVEL   = 14;
  localparam int SC_FLAG    = 15;
  // reset values and counter maximum
  localparam logic [15:0] CFG_RST   = 16'h0000;
  localparam logic [15:0] SC_RST    = 16'h0000;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  // count source codes, 0..5 are prescaler taps
  localparam logic [2:0] SRC_RISE = 3'h6;
  localparam logic [2:0] SRC_FALL = 3'h7;
  // load edge codes
  localparam logic [1:0] LDE_RISE = 2'h1;
  localparam logic [1:0] LDE_FALL = 2'h2;
  localparam logic [1:0] LDE_BOTH = 2'h3;
  // submodule number of channel 0
  localparam logic [5:0] SUBMOD_BASE = 6'h0C;
endpackage

//--- pin_edge.sv
// Purpose: synchronise a pin and report its level and edges
// Assumes: pin toggles at most at a quarter of clk
// Notes:   edges are swallowed while hold is high
`timescale 1ns/1ps
module pin_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin side
  input  wire logic pin,
  input  wire logic hold,
  // results
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic change;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign change = (s2_q == s3_q) && (s3_q != level_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (change) begin
      level_q <= s3_q;
    end
  end

  assign level = level_q;
  assign rise  = change && s3_q && !hold;
  assign fall  = change && !s3_q && !hold;
endmodule

//--- tb_modulus_counter_submodule.sv
// Purpose: self-checking bench of the modulus timer
// Assumes: channel 0 pins are exercised, others held low
// Notes:   count pin events come from event_source
`timescale 1ns/1ps
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  end \
end
module tb_modulus_counter_submodule;
  logic        clk, rst_n, wr, rd, iack, ld_pin, pin, busy;
  logic        tb_first_drv, tb_second_drv, vector_valid;
  logic [5:0]  addr;
  logic [15:0] wdata, rdata, tb_first, tb_second;
  logic [3:0]  edges, arb_number;
  logic [2:0]  ip_mask, irq_level;
  logic [7:0]  vector;
  int          miscompares, check_count, cycles;

  modulus_timer DUT (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .external_count_input({2'b00, pin}),
    .load_input({2'b00, ld_pin}),
    .tb_first, .tb_first_drv, .tb_second, .tb_second_drv,
    .ip_mask, .iack, .irq_level, .arb_number, .vector, .vector_valid
  );
  event_source far (.clk, .rst_n, .edges, .pin, .busy);

  task automatic wr_r(input logic [5:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_r(input logic [5:0] a, input logic [15:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge clk);
  endtask
  task automatic ev(input logic [3:0] n);
    edges <= n;
    repeat (2) @(posedge clk);
    edges <= 4'h0;
    for (int i = 0; i < 200 && busy; i++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task automatic t_regs;
    repeat (20) @(posedge clk);
    chk_r(6'h00, modulus_timer_pkg::CFG_RST);
    chk_r(6'h10, modulus_timer_pkg::SC_RST);
    chk_r(6'h11, modulus_timer_pkg::CNT_RST);
    chk_r(6'h12, modulus_timer_pkg::LATCH_RST);
    wr_r(6'h00, 16'hFEFF);
    chk_r(6'h00, 16'h00C7);
    wr_r(6'h10, 16'h1FFF); // one bus only
    chk_r(6'h10, 16'h1F37);
    wr_r(6'h10, 16'h0000);
    wr_r(6'h3F, 16'hFFFF);
    chk_r(6'h3F, 16'h0000);
    chk_r(6'h13, 16'h0000);
    wr_r(6'h15, 16'h1234);
    chk_r(6'h16, 16'h1234);
    chk_r(6'h11, 16'h0000);
    $display("regs test done");
  endtask
  task automatic t_events;
    wr_r(6'h00, 16'h0100);
    wr_r(6'h10, {13'h0, modulus_timer_pkg::SRC_RISE});
    wr_r(6'h11, 16'hFFFD); // minus three events
    ev(4'h4);
    chk_r(6'h11, 16'hFFFF);
    chk_r(6'h10, 16'h0006);
    ev(4'h2);
    chk_r(6'h11, 16'hFFFD);
    chk_r(6'h10, 16'h8006);
    wr_r(6'h10, {13'h0, modulus_timer_pkg::SRC_FALL});
    ev(4'h1);
    chk_r(6'h10, 16'h4007);
    chk_r(6'h11, 16'hFFFD);
    ev(4'h1);
    chk_r(6'h11, 16'hFFFE);
    $display("events test done");
  endtask
  task automatic t_mod;
    wr_r(6'h12, 16'h0000);
    chk_r(6'h11, 16'hFFFE);
    ev(4'h4);
    chk_r(6'h11, 16'h0000);
    ev(4'h2);
    chk_r(6'h11, 16'h0001);
    wr_r(6'h11, 16'hFFFF);
    wr_r(6'h10, 16'h0007);
    ev(4'h2);
    chk_r(6'h10, 16'h8007);
    wr_r(6'h10, 16'h0007);
    ev(4'h2);
    chk_r(6'h10, 16'h8007);
    chk_r(6'h11, 16'hFFFF);
    wr_r(6'h12, 16'h1234);
    wr_r(6'h10, 16'h0017);
    ld_pin <= 1'b1;
    repeat (10) @(posedge clk);
    chk_r(6'h11, 16'h1234);
    wr_r(6'h12, 16'h5678);
    wr_r(6'h10, 16'h0027);
    ld_pin <= 1'b0;
    repeat (10) @(posedge clk);
    chk_r(6'h11, 16'h5678);
    $display("modulus test done");
  endtask
  task automatic t_irq;
    wr_r(6'h00, 16'h0185);
    wr_r(6'h10, 16'h0B07);
    wr_r(6'h11, 16'hFFFF);
    ip_mask <= 3'h2;
    ev(4'h2);
    `CHK(irq_level, 3'h3)
    `CHK(arb_number, 4'hD)
    iack <= 1'b1;
    @(posedge clk);
    iack <= 1'b0;
    ip_mask <= 3'h3;
    #1;
    `CHK(vector_valid, 1'b1)
    `CHK(vector, 8'h8C)
    repeat (3) @(posedge clk);
    `CHK(irq_level, 3'h0)
    ip_mask <= 3'h0;
    wr_r(6'h10, 16'h8807);
    repeat (2) @(posedge clk);
    `CHK(irq_level, 3'h0)
    $display("interrupt test done");
  endtask
  task automatic t_tbus;
    wr_r(6'h10, 16'h1007);
    repeat (3) @(posedge clk);
    `CHK({tb_first_drv, tb_second_drv, tb_first}, 18'h2FFFF)
    wr_r(6'h10, 16'h2007);
    repeat (3) @(posedge clk);
    `CHK({tb_first_drv, tb_second_drv, tb_second}, 18'h1FFFF)
    `CHK(tb_first, 16'h0000)
    $display("time base test done");
  endtask
  // prescaler restarts from zero when run is set: tap k ticks every 2^(k+1) cycles
  task automatic t_taps;
    for (int k = 0; k < 6; k++) begin
      wr_r(6'h00, 16'h0000);
      wr_r(6'h11, 16'h0000);
      wr_r(6'h10, {13'h0, 3'(k)});
      chk_r(6'h11, 16'h0000);
      wr_r(6'h00, 16'h0100);
      repeat ((5 << k) - 1) @(posedge clk);
      chk_r(6'h11, 16'h0002);
    end
    $display("taps test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, far above the less than one thousand cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    {wr, rd, iack, ld_pin, addr, wdata, edges, ip_mask} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_events();
    t_mod();
    t_irq();
    t_tbus();
    t_taps();
    summarize();
  end
endmodule
